// file: rtl/afe_clk_defs.svh
// Register offsets, reset values, divider limits, a source code and the key value of the clock block.
// Assumes a byte-addressed register port and 32-bit data, with registers in the low bits.
//
// Overview of operation
// - Clock-select writes blocked unless key unlocked.
// - Key value unlocks; any other value relocks.
// - Configuration writes blocked unless key unlocked.
// - Select bit 0 moves system clock to 32 kHz.
// - Bit 8 powers down regulator; resets one.
// - Bit 7 enables 1.11 V common-mode buffer.
// - Bit 6 enables 1.82 V reference buffer.
// - Bit 3 enables repeated conversions.
// - Bit 2 enables conversions.
// - Bit 1 powers down fast reference; resets one.
// - Bit 0 powers down fast oscillator; resets zero.
// - Slow oscillator clocks the wake-up timer.
// - External clock pin is a selectable source.
// - After reset, fast internal oscillator drives system.
// - Converter clock is root over 1 or 2.
// - System divider 1 to 32, saturating.
// - System divider zero acts as one.
// - Converter source field encodes four sources.
// - System source field uses same encoding.
`ifndef AFE_CLK_DEFS_SVH
`define AFE_CLK_DEFS_SVH

`define AFE_CLOCK_DIVIDER_CONFIG_ADDR 16'h0408
`define AFE_CLOCK_GATE_ENABLE_ADDR 16'h0410
`define AFE_CLOCK_SOURCE_SELECT_ADDR 16'h0414
`define AFE_OSCILLATOR_UNLOCK_KEY_ADDR 16'h0A0C
`define AFE_OSCILLATOR_CONTROL_ADDR 16'h0A10
`define AFE_RESET_CONTROL_UNLOCK_KEY_ADDR 16'h0A5C
`define AFE_SLOW_OSCILLATOR_TEST_ADDR 16'h0A6C
`define AFE_CHOP_AND_TIMER_CLOCK_ENABLE_ADDR 16'h0A70
`define AFE_FAST_OSCILLATOR_CONFIG_ADDR 16'h20BC
`define AFE_LOWPOWER_UNLOCK_KEY_ADDR 16'h210C
`define AFE_LOWPOWER_CLOCK_SELECT_ADDR 16'h2110
`define AFE_LOWPOWER_CONFIG_ADDR 16'h2114

`define AFE_CLOCK_DIVIDER_CONFIG_RST 16'h0441
`define AFE_CLOCK_GATE_ENABLE_RST 16'h01C0
`define AFE_CLOCK_SOURCE_SELECT_RST 16'h0000
`define AFE_OSCILLATOR_CONTROL_RST 16'h0003
`define AFE_SLOW_OSCILLATOR_TEST_RST 16'h0088
`define AFE_CHOP_AND_TIMER_CLOCK_ENABLE_RST 16'h0004
`define AFE_FAST_OSCILLATOR_CONFIG_RST 16'h0034
`define AFE_LOWPOWER_CONFIG_RST 9'h102

`define AFE_LOWPOWER_KEY_VALUE 20'hC59D6
`define AFE_SYS_DIV_MAX 6'h20
`define AFE_CONV_DIV_MAX 4'h2
`define AFE_SRC_SLOW_INTERNAL 2'h2

`endif

// file: rtl/afe_clk_pkg.sv
// Types shared by the clock and low-power control block.
// Assumes the defines header is compiled alongside; this package holds types only.
package afe_clk_pkg;

	// Sampled levels of the four clock sources, indexed by the source encoding.
	typedef struct packed {
		logic extPin;
		logic slowOsc;
		logic crystal;
		logic fastOsc;
	} afe_src_t;

	// Low-power analog controls driven to the front end.
	typedef struct packed {
		logic analogRegulatorPowerdown;
		logic commonModeBufferEnable;
		logic referenceBufferEnable;
		logic repeatConversionEnable;
		logic conversionEnable;
		logic fastReferencePowerdown;
		logic fastOscillatorPowerdown;
	} afe_lp_t;

	// One divided, switchable clock channel.
	typedef struct packed {
		logic [1:0] sel;
		logic [5:0] cnt;
		logic srcPrev;
		logic out;
	} afe_chan_t;

	// Whole state of the block.
	typedef struct packed {
		logic [15:0] divCfg;
		logic [15:0] gateEn;
		logic [15:0] srcSel;
		logic [15:0] oscillator_unlock_key;
		logic [15:0] oscCtl;
		logic [15:0] slowTst;
		logic [15:0] chopEn;
		logic [15:0] fastCfg;
		logic [19:0] lpKey;
		logic lpClkSel;
		logic [8:0] lpCon;
		afe_chan_t sysCh;
		afe_chan_t adcCh;
		logic wakeClk;
		afe_lp_t lpOut;
		logic [31:0] rdData;
	} afe_state_t;

endpackage

// file: rtl/afe_clock_and_lowpower_ctrl.sv
// Clock source selection, division and low-power configuration registers.
// Assumes source clock levels arrive synchronous to clk, well below half its rate,
// and a register master that never overlaps read and write strobes.
`timescale 1ns/10ps
`default_nettype none
`include "afe_clk_defs.svh"

module afe_clock_and_lowpower_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	input wire afe_clk_pkg::afe_src_t srcLvl,
	output logic sysClkOut,
	output logic adcClkOut,
	output logic wakeTimerClk,
	output afe_clk_pkg::afe_lp_t lpCtl
);

	// Registered state and its next value.
	afe_clk_pkg::afe_state_t st_r;
	afe_clk_pkg::afe_state_t st_nxt;
	// Key comparison result; only the lowpower key gates the protected pair.
	logic lpUnlocked;
	// Effective divider values after clamping.
	logic [5:0] sysDiv;
	logic [5:0] adcDiv;
	// Requested sources for each channel.
	logic [1:0] sysReq;
	logic [1:0] adcReq;

	// Steps one clock channel. A source change waits until both the output and the
	// current source are low, so no runt pulse is cut; the output then rises only on a
	// genuine edge of the new source. The cost is a switch latency of up to one old output period plus one new source period.
	function automatic afe_clk_pkg::afe_chan_t chanStep(
		input afe_clk_pkg::afe_chan_t ch,
		input logic [3:0] lvls,
		input logic [1:0] req,
		input logic [5:0] div
	);
		afe_clk_pkg::afe_chan_t n;
		logic lvl;
		logic rise;
		logic [5:0] cntNxt;
		logic [5:0] half;
		n = ch;
		lvl = lvls[ch.sel];
		rise = lvl & ~ch.srcPrev;
		cntNxt = ch.cnt;
		half = 6'((7'(div) + 7'h01) >> 1);
		if ((req != ch.sel) && !ch.out && !lvl) begin
			// Park low and restart the divider one step before wrap.
			n.sel = req;
			n.cnt = div - 6'h01;
			n.srcPrev = lvls[req];
			n.out = 1'b0;
		end else begin
			// Divider advances on each rising edge of the selected source.
			if (rise) begin
				cntNxt = (ch.cnt + 6'h01 >= div) ? 6'h00 : ch.cnt + 6'h01;
			end
			n.cnt = cntNxt;
			n.srcPrev = lvl;
			if (div == 6'h01) begin
				// Undivided: follow the source, but only rise on a real edge.
				n.out = rise | (ch.out & lvl);
			end else begin
				// Divided: high for the first half of each period, rounded up to whole source periods.
				n.out = (cntNxt < half);
			end
		end
		return n;
	endfunction

	// Key check: only the exact value opens the protected registers.
	assign lpUnlocked = (st_r.lpKey == `AFE_LOWPOWER_KEY_VALUE);

	// Divider clamps and source requests.
	always_comb begin
		// Zero acts as one and values above the maximum saturate.
		if (st_r.divCfg[5:0] == 6'h00) begin
			sysDiv = 6'h01;
		end else if (st_r.divCfg[5:0] > `AFE_SYS_DIV_MAX) begin
			sysDiv = `AFE_SYS_DIV_MAX;
		end else begin
			sysDiv = st_r.divCfg[5:0];
		end
		// Converter divider only knows one and two; others are clamped the same way.
		if (st_r.divCfg[9:6] == 4'h0) begin
			adcDiv = 6'h01;
		end else if (st_r.divCfg[9:6] > `AFE_CONV_DIV_MAX) begin
			adcDiv = 6'h02;
		end else begin
			adcDiv = {2'h0, st_r.divCfg[9:6]};
		end
		// The low-power switch overrides the normal system source field.
		sysReq = st_r.lpClkSel ? `AFE_SRC_SLOW_INTERNAL : st_r.srcSel[1:0];
		adcReq = st_r.srcSel[3:2];
	end

	// Next-state logic for registers, channels and read data.
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdData = 32'h0000_0000;
		// Register writes; unmapped addresses are ignored.
		if (regWr) begin
			case (regAddr)
				`AFE_CLOCK_DIVIDER_CONFIG_ADDR: begin
					st_nxt.divCfg = regWrData[15:0];
				end
				`AFE_CLOCK_GATE_ENABLE_ADDR: begin
					st_nxt.gateEn = regWrData[15:0];
				end
				`AFE_CLOCK_SOURCE_SELECT_ADDR: begin
					st_nxt.srcSel = {12'h000, regWrData[3:0]};
				end
				`AFE_OSCILLATOR_UNLOCK_KEY_ADDR: begin
					st_nxt.oscillator_unlock_key = regWrData[15:0];
				end
				`AFE_OSCILLATOR_CONTROL_ADDR: begin
					st_nxt.oscCtl = regWrData[15:0];
				end
				`AFE_SLOW_OSCILLATOR_TEST_ADDR: begin
					st_nxt.slowTst = regWrData[15:0];
				end
				`AFE_CHOP_AND_TIMER_CLOCK_ENABLE_ADDR: begin
					st_nxt.chopEn = regWrData[15:0];
				end
				`AFE_FAST_OSCILLATOR_CONFIG_ADDR: begin
					st_nxt.fastCfg = regWrData[15:0];
				end
				`AFE_LOWPOWER_UNLOCK_KEY_ADDR: begin
					// Any value is stored; only the key value unlocks.
					st_nxt.lpKey = regWrData[19:0];
				end
				`AFE_LOWPOWER_CLOCK_SELECT_ADDR: begin
					if (lpUnlocked) begin
						st_nxt.lpClkSel = regWrData[0];
					end
				end
				`AFE_LOWPOWER_CONFIG_ADDR: begin
					if (lpUnlocked) begin
						st_nxt.lpCon = regWrData[8:0];
					end
				end
				default: begin
					// Nothing is stored for an unmapped or write-only key address.
				end
			endcase
		end
		// Register reads; the answer stands in the following cycle only.
		if (regRd) begin
			case (regAddr)
				`AFE_CLOCK_DIVIDER_CONFIG_ADDR: st_nxt.rdData = {16'h0000, st_r.divCfg};
				`AFE_CLOCK_GATE_ENABLE_ADDR: st_nxt.rdData = {16'h0000, st_r.gateEn};
				`AFE_CLOCK_SOURCE_SELECT_ADDR: st_nxt.rdData = {16'h0000, st_r.srcSel};
				`AFE_OSCILLATOR_UNLOCK_KEY_ADDR: st_nxt.rdData = {16'h0000, st_r.oscillator_unlock_key};
				`AFE_OSCILLATOR_CONTROL_ADDR: st_nxt.rdData = {16'h0000, st_r.oscCtl};
				`AFE_SLOW_OSCILLATOR_TEST_ADDR: st_nxt.rdData = {16'h0000, st_r.slowTst};
				`AFE_CHOP_AND_TIMER_CLOCK_ENABLE_ADDR: st_nxt.rdData = {16'h0000, st_r.chopEn};
				`AFE_FAST_OSCILLATOR_CONFIG_ADDR: st_nxt.rdData = {16'h0000, st_r.fastCfg};
				`AFE_LOWPOWER_UNLOCK_KEY_ADDR: st_nxt.rdData = {12'h000, st_r.lpKey};
				`AFE_LOWPOWER_CLOCK_SELECT_ADDR: st_nxt.rdData = {31'h0000_0000, st_r.lpClkSel};
				`AFE_LOWPOWER_CONFIG_ADDR: st_nxt.rdData = {23'h00_0000, st_r.lpCon};
				default: st_nxt.rdData = 32'h0000_0000;
			endcase
		end
		// Clock channels: system may fall back to the slow oscillator, and the
		// external pin is the fourth selectable source.
		st_nxt.sysCh = chanStep(st_r.sysCh, srcLvl, sysReq, sysDiv);
		st_nxt.adcCh = chanStep(st_r.adcCh, srcLvl, adcReq, adcDiv);
		// Wake-up timer always runs from the slow internal oscillator.
		st_nxt.wakeClk = srcLvl.slowOsc;
		// Analog controls follow the configuration fields.
		st_nxt.lpOut.analogRegulatorPowerdown = st_r.lpCon[8];
		st_nxt.lpOut.commonModeBufferEnable = st_r.lpCon[7];
		st_nxt.lpOut.referenceBufferEnable = st_r.lpCon[6];
		st_nxt.lpOut.repeatConversionEnable = st_r.lpCon[3];
		st_nxt.lpOut.conversionEnable = st_r.lpCon[2];
		st_nxt.lpOut.fastReferencePowerdown = st_r.lpCon[1];
		st_nxt.lpOut.fastOscillatorPowerdown = st_r.lpCon[0];
	end

	// State register with synchronous reset to the documented defaults.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r.divCfg <= `AFE_CLOCK_DIVIDER_CONFIG_RST;
			st_r.gateEn <= `AFE_CLOCK_GATE_ENABLE_RST;
			st_r.srcSel <= `AFE_CLOCK_SOURCE_SELECT_RST;
			st_r.oscillator_unlock_key <= 16'h0000;
			st_r.oscCtl <= `AFE_OSCILLATOR_CONTROL_RST;
			st_r.slowTst <= `AFE_SLOW_OSCILLATOR_TEST_RST;
			st_r.chopEn <= `AFE_CHOP_AND_TIMER_CLOCK_ENABLE_RST;
			st_r.fastCfg <= `AFE_FAST_OSCILLATOR_CONFIG_RST;
			st_r.lpKey <= 20'h0_0000;
			st_r.lpClkSel <= 1'b0;
			st_r.lpCon <= `AFE_LOWPOWER_CONFIG_RST;
			st_r.sysCh <= '0;
			st_r.adcCh <= '0;
			st_r.wakeClk <= 1'b0;
			// Regulator and fast reference start powered down; the oscillator stays on.
			st_r.lpOut <= 7'h42;
			st_r.rdData <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from the state flops.
	assign regRdData = st_r.rdData;
	assign sysClkOut = st_r.sysCh.out;
	assign adcClkOut = st_r.adcCh.out;
	assign wakeTimerClk = st_r.wakeClk;
	assign lpCtl = st_r.lpOut;

	// Checks on the design's own behaviour.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_lpsel_locked: assert property (
		(regWr && regAddr == `AFE_LOWPOWER_CLOCK_SELECT_ADDR && !lpUnlocked)
		|=> $stable(st_r.lpClkSel))
		else $error("Clock-select changed while locked.");

	a_lpcon_locked: assert property (
		(regWr && regAddr == `AFE_LOWPOWER_CONFIG_ADDR && !lpUnlocked)
		|=> ##1 $stable(lpCtl))
		else $error("Low-power controls changed while locked.");

	a_key_unlock: assert property (
		(regWr && regAddr == `AFE_LOWPOWER_UNLOCK_KEY_ADDR)
		|=> (lpUnlocked == ($past(regWrData[19:0]) == `AFE_LOWPOWER_KEY_VALUE)))
		else $error("Key write gave wrong lock state.");

	a_lp_ctl_follow: assert property (
		(regWr && regAddr == `AFE_LOWPOWER_CONFIG_ADDR && lpUnlocked)
		|=> ##1 (lpCtl.analogRegulatorPowerdown == $past(regWrData[8], 2)
		&& lpCtl.fastOscillatorPowerdown == $past(regWrData[0], 2)))
		else $error("Low-power controls did not follow the write.");

	a_slow_switch: assert property (
		st_r.lpClkSel |-> sysReq == `AFE_SRC_SLOW_INTERNAL)
		else $error("Slow switch did not request slow oscillator.");

	a_sys_div_range: assert property (
		(sysDiv >= 6'h01) && (sysDiv <= `AFE_SYS_DIV_MAX)
		&& ((st_r.divCfg[5:0] <= 6'h01) -> (sysDiv == 6'h01)))
		else $error("System divider out of range.");

	a_adc_div_range: assert property (
		(adcDiv == 6'h01) || (adcDiv == 6'h02))
		else $error("Converter divider not one or two.");

	a_switch_clean: assert property (
		(st_nxt.sysCh.sel != st_r.sysCh.sel) |-> (!sysClkOut ##1 !sysClkOut))
		else $error("System source switched while clock high.");

	a_reset_source: assert property (
		$rose(rst_n) |-> (st_r.sysCh.sel == 2'h0))
		else $error("System source not fast oscillator after reset.");

	c_unlock_write: cover property (
		(regWr && regAddr == `AFE_LOWPOWER_UNLOCK_KEY_ADDR) ##[1:8] lpUnlocked);
	c_slow_entry: cover property (
		st_r.lpClkSel ##[1:200] (st_r.sysCh.sel == `AFE_SRC_SLOW_INTERNAL));
	c_divided_clock: cover property ((sysDiv == 6'h04) ##1 $rose(sysClkOut));

endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the clock and low-power control block.
// Assumes the defines header and the types package are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "afe_clk_defs.svh"

module tb;
	logic clk = 1'b0; // 200 MHz bench clock.
	logic rst_n = 1'b0; // Synchronous reset, active low.
	logic [15:0] regAddr = 16'h0000;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdData;
	afe_clk_pkg::afe_src_t srcLvl = '0; // Source periods 8, 10, 12 and 14 cycles.
	logic sysClkOut;
	logic adcClkOut;
	logic wakeTimerClk;
	afe_clk_pkg::afe_lp_t lpCtl;
	int err_count = 0;
	int n_checks = 0;
	int seed = 32'h22A08D44; // Fixed seed keeps every run the same.
	int cyc = 0;
	int sysHi = 0;
	int adcHi = 0;

	afe_clock_and_lowpower_ctrl dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.srcLvl(srcLvl), .sysClkOut(sysClkOut), .adcClkOut(adcClkOut),
		.wakeTimerClk(wakeTimerClk), .lpCtl(lpCtl));

	// Clock generator.
	initial forever #2.5 clk = ~clk;

	// Free-running sources; distinct periods make the selected one recognisable.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		srcLvl <= {(cyc % 14) < 7, (cyc % 12) < 6, (cyc % 10) < 5, (cyc % 8) < 4};
	end

	// Every high pulse must last at least the shortest source half period, so no runts.
	always @(negedge clk) begin
		if (sysClkOut === 1'b1) begin
			sysHi <= sysHi + 1;
		end else begin
			if (sysHi > 0) check(32'(sysHi >= 4), 32'h1);
			sysHi <= 0;
		end
		if (adcClkOut === 1'b1) begin
			adcHi <= adcHi + 1;
		end else begin
			if (adcHi > 0) check(32'(adcHi >= 4), 32'h1);
			adcHi <= 0;
		end
	end

	// Counts a comparison and reports a mismatch at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic close_out();
		if (err_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One-cycle write strobe; the strobe drops at the edge that takes it.
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just after that edge.
	task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 check(regRdData, exp);
	endtask

	function automatic logic outOf(input logic adc);
		return adc ? adcClkOut : sysClkOut;
	endfunction

	// Waits, bounded, for a rising edge of the chosen output.
	task automatic wait_rise(input logic adc, input logic p0, output int n);
		logic p;
		logic c;
		p = p0;
		n = 0;
		while (n < 1200) begin
			@(negedge clk);
			n++;
			c = outOf(adc);
			if (p === 1'b0 && c === 1'b1) break;
			p = c;
		end
	endtask

	// Lets a switch settle, then measures one period and its high time in cycles.
	task automatic meas(input logic adc, output int per, output int hi);
		int n;
		wait_rise(adc, 1'b1, n);
		wait_rise(adc, 1'b1, n);
		hi = 0;
		do begin
			@(negedge clk);
			hi++;
		end while (outOf(adc) === 1'b1 && hi < 1200);
		wait_rise(adc, 1'b0, n);
		per = hi + n;
	endtask

	function automatic int per_of(input int s);
		return 8 + 2 * s;
	endfunction

	// A divided clock stays high for the larger half of its source periods.
	function automatic int hi_of(input int s, input int n);
		return (n == 1) ? (4 + s) : ((n + 1) / 2) * per_of(s);
	endfunction

	// Watchdog sized well above the longest measured sequence.
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		close_out();
	end

	initial begin
		logic [15:0] ra [12];
		logic [31:0] rv [12];
		int sdC [5];
		logic [31:0] r;
		logic [5:0] sd;
		logic [3:0] ad;
		logic p;
		int per;
		int hi;
		int s;
		int a;
		int sN;
		int aN;
		ra = '{`AFE_CLOCK_DIVIDER_CONFIG_ADDR, `AFE_CLOCK_GATE_ENABLE_ADDR,
			`AFE_CLOCK_SOURCE_SELECT_ADDR, `AFE_OSCILLATOR_UNLOCK_KEY_ADDR,
			`AFE_OSCILLATOR_CONTROL_ADDR, `AFE_RESET_CONTROL_UNLOCK_KEY_ADDR,
			`AFE_SLOW_OSCILLATOR_TEST_ADDR, `AFE_CHOP_AND_TIMER_CLOCK_ENABLE_ADDR,
			`AFE_FAST_OSCILLATOR_CONFIG_ADDR, `AFE_LOWPOWER_UNLOCK_KEY_ADDR,
			`AFE_LOWPOWER_CLOCK_SELECT_ADDR, `AFE_LOWPOWER_CONFIG_ADDR};
		rv = '{32'h0441, 32'h01C0, 32'h0, 32'h0, 32'h0003, 32'h0, 32'h0088, 32'h0004,
			32'h0034, 32'h0, 32'h0, 32'h0102};
		sdC = '{0, 1, 2, 32, 40};
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check({25'h0, lpCtl}, 32'h42);
		for (int i = 0; i < 12; i++) rchk(ra[i], rv[i]);
		rchk(16'h0000, 32'h0);
		meas(1'b0, per, hi);
		check(per, 32'd8);
		// Plain registers read back all 16 bits; the select keeps only its fields.
		for (int i = 1; i < 9; i++) begin
			r = $random(seed);
			wr(ra[i], {16'h0, r[15:0]});
			rchk(ra[i], (i == 5) ? 32'h0 : (i == 2) ? {28'h0, r[3:0]} : {16'h0, r[15:0]});
		end
		wr(16'h0000, 32'hFFFF_FFFF);
		rchk(16'h0000, 32'h0);
		@(negedge clk);
		p = srcLvl.slowOsc;
		repeat (30) begin
			@(negedge clk);
			check({31'h0, wakeTimerClk}, {31'h0, p});
			p = srcLvl.slowOsc;
		end
		// Locked writes are dropped; the key opens the config register and a wrong key relocks it.
		wr(`AFE_LOWPOWER_CONFIG_ADDR, 32'h0);
		rchk(`AFE_LOWPOWER_CONFIG_ADDR, 32'h0102);
		wr(`AFE_LOWPOWER_CLOCK_SELECT_ADDR, 32'h1);
		rchk(`AFE_LOWPOWER_CLOCK_SELECT_ADDR, 32'h0);
		wr(`AFE_LOWPOWER_UNLOCK_KEY_ADDR, 32'hC59D6);
		rchk(`AFE_LOWPOWER_UNLOCK_KEY_ADDR, 32'hC59D6);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			if (i < 3) r = (i == 0) ? 32'h0 : (i == 1) ? 32'h1FF : 32'h1C4;
			wr(`AFE_LOWPOWER_CONFIG_ADDR, {23'h0, r[8:0]});
			rchk(`AFE_LOWPOWER_CONFIG_ADDR, {23'h0, r[8:0]});
			check({25'h0, lpCtl}, {25'h0, r[8:6], r[3:0]});
		end
		wr(`AFE_LOWPOWER_UNLOCK_KEY_ADDR, 32'hC59D7);
		wr(`AFE_LOWPOWER_CONFIG_ADDR, 32'h0);
		rchk(`AFE_LOWPOWER_CONFIG_ADDR, {23'h0, r[8:0]});
		// Sources, dividers and their saturation, with corner values first.
		for (int i = 0; i < 12; i++) begin
			r = $random(seed);
			s = (i < 4) ? i : r[1:0];
			a = (i < 4) ? 3 - i : r[3:2];
			sd = (i < 5) ? 6'(sdC[i]) : r[13:8];
			ad = (i < 4) ? 4'(i) : r[19:16];
			sN = (sd == 0) ? 1 : (sd > 32) ? 32 : sd;
			aN = (ad == 0) ? 1 : (ad > 2) ? 2 : ad;
			wr(`AFE_CLOCK_DIVIDER_CONFIG_ADDR, {16'h0, 6'h01, ad, sd});
			wr(`AFE_CLOCK_SOURCE_SELECT_ADDR, {28'h0, 2'(a), 2'(s)});
			meas(1'b0, per, hi);
			check(per, sN * per_of(s));
			check(hi, hi_of(s, sN));
			meas(1'b1, per, hi);
			check(per, aN * per_of(a));
		end
		// The low-power switch overrides the select field and releases it again.
		wr(`AFE_CLOCK_DIVIDER_CONFIG_ADDR, 32'h0441);
		wr(`AFE_CLOCK_SOURCE_SELECT_ADDR, 32'h3);
		wr(`AFE_LOWPOWER_UNLOCK_KEY_ADDR, 32'hC59D6);
		wr(`AFE_LOWPOWER_CLOCK_SELECT_ADDR, 32'h1);
		meas(1'b0, per, hi);
		check(per, 32'd12);
		wr(`AFE_LOWPOWER_CLOCK_SELECT_ADDR, 32'h0);
		meas(1'b0, per, hi);
		check(per, 32'd14);
		close_out();
	end
endmodule
`default_nettype wire
